// *** design/dcts_top.sv ***
`timescale 1ns/1ps
module dcts_top (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic function_strobe_i,
  input wire logic [3:0] function_nibble_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic irq_o,
  input wire logic drive_ready_i,
  input wire logic drive_read_clk_i,
  input wire logic [15:0] drive_bus_i,
  input wire logic drive_parity_i,
  input wire logic drive_done_i,
  output logic [15:0] drive_bus_o,
  output logic [4:0] drive_code_o,
  output logic drive_fdr_o,
  output logic [2:0] sync_phase_o,
  input wire logic [11:0] buf_data_i,
  output logic [11:0] buf_data_o,
  output logic pointer_a_strobe_o,
  output logic pointer_b_strobe_o,
  output logic [71:0] out_word_o,
  output logic out_word_valid_o,
  output logic out_clear_o,
  input wire logic out_word_req_i
);

  typedef struct packed {
    dcts_pkg::dcts_fn_t fn;
    logic [1:0] acc_cnt;
    logic [3:0] modifier;
    logic [15:0] acc;
    logic [15:0] param;
    logic int_en;
    logic done;
    logic perr;
    logic busy;
    logic dir_wr;
    logic odd;
    logic [2:0] sync;
    logic s1_rdy;
    logic s2_rdy;
    logic s3_rdy;
    logic s1_clk;
    logic s2_clk;
    logic s3_clk;
    logic s1_done;
    logic s2_done;
    logic [15:0] s1_bus;
    logic [15:0] s2_bus;
    logic s1_par;
    logic s2_par;
    logic asm_on;
    logic burst_on;
    logic [4:0] pcount;
    logic [7:0] bursts;
    logic sector_done;
    logic [1:0] paddr;
    logic [63:0] asm_word;
    logic wfp;
    logic wreq;
    logic start_a;
    logic start_b;
    logic start_wr_a;
    logic start_wr_b;
    logic cont;
    dcts_pkg::dcts_buf_t brd;
    logic [71:0] bshift;
    logic [2:0] bcnt;
    logic [11:0] bdata;
    logic pa;
    logic pb;
    logic [71:0] wshift;
    logic [71:0] oword;
    logic ovalid;
    logic clear;
    logic [4:0] code;
    logic [15:0] bus;
    logic fdr;
    logic [15:0] rdata;
  } dcts_state_t;

  dcts_state_t q;
  dcts_state_t d;

  // Check bit k is the parity of every eighth data bit starting at k
  function automatic logic [7:0] dcts_check(input logic [63:0] w);
    logic [7:0] cb;
    cb = 8'h00;
    for (int i = 0; i < dcts_pkg::WORD_W; i++) begin
      cb[i % dcts_pkg::CB_W] = cb[i % dcts_pkg::CB_W] ^ w[i];
    end
    return cb;
  endfunction : dcts_check

  logic rclk_rise;
  logic rdy_rise;
  logic [15:0] parcel;
  assign rclk_rise = q.s2_clk & ~q.s3_clk;
  assign rdy_rise = q.s2_rdy & ~q.s3_rdy;

  always_comb begin
    d = q;
    d.wfp = 1'b0;
    d.wreq = 1'b0;
    d.start_a = 1'b0;
    d.start_b = 1'b0;
    d.start_wr_a = 1'b0;
    d.start_wr_b = 1'b0;
    d.cont = 1'b0;
    d.pa = 1'b0;
    d.pb = 1'b0;
    d.ovalid = 1'b0;
    d.clear = 1'b0;
    d.fdr = 1'b0;
    parcel = q.s2_bus;

    d.sync = (q.sync == dcts_pkg::SYNC_LAST) ? 3'h0 : q.sync + 3'h1;

    // Drive pins arrive from outside; two stages before use
    d.s1_rdy = drive_ready_i;
    d.s2_rdy = q.s1_rdy;
    d.s3_rdy = q.s2_rdy;
    d.s1_clk = drive_read_clk_i;
    d.s2_clk = q.s1_clk;
    d.s3_clk = q.s2_clk;
    d.s1_done = drive_done_i;
    d.s2_done = q.s1_done;
    d.s1_bus = drive_bus_i;
    d.s2_bus = q.s1_bus;
    d.s1_par = drive_parity_i;
    d.s2_par = q.s1_par;

    // Request code changes only after the drive has seen the first request
    if (q.fdr && q.code != dcts_pkg::CODE_CONT) begin
      d.code = dcts_pkg::CODE_CONT;
    end

    unique case (q.fn)
      dcts_pkg::FN_IDLE: begin
        if (function_strobe_i) begin
          d.modifier = function_nibble_i;
          d.fn = dcts_pkg::FN_CMD;
        end
      end
      dcts_pkg::FN_CMD: begin
        d.acc_cnt = 2'h0;
        d.fn = (function_nibble_i == dcts_pkg::CMD_TRANSFER) ? dcts_pkg::FN_ACC
                                                              : dcts_pkg::FN_IDLE;
      end
      dcts_pkg::FN_ACC: begin
        d.acc = {q.acc[11:0], function_nibble_i};
        d.acc_cnt = q.acc_cnt + 2'h1;
        if (q.acc_cnt == dcts_pkg::ACC_LAST) begin
          d.fn = dcts_pkg::FN_IDLE;
          d.busy = 1'b1;
          d.odd = q.modifier[0];
          d.dir_wr = (d.acc[4:0] == dcts_pkg::CODE_WRITE);
          d.code = d.acc[4:0];
          d.bus = q.param;
          d.fdr = 1'b1;
          d.bursts = 8'h00;
          d.sector_done = 1'b0;
          d.burst_on = 1'b0;
          d.paddr = 2'h0;
          if (d.acc[4:0] == dcts_pkg::CODE_READ) begin
            d.start_a = ~q.modifier[0];
            d.start_b = q.modifier[0];
            d.asm_on = 1'b1;
            d.brd = dcts_pkg::BUF_MODE;
          end else if (d.acc[4:0] == dcts_pkg::CODE_WRITE) begin
            d.start_wr_a = ~q.modifier[0];
            d.start_wr_b = q.modifier[0];
            d.clear = 1'b1;
            d.wshift = '0;
            d.oword = '0;
            d.asm_on = 1'b0;
            d.brd = dcts_pkg::BUF_MODE;
          end
        end
      end
    endcase

    // Drive input unit: burst counting and parcel forwarding
    if (q.asm_on && rdy_rise) begin
      d.burst_on = 1'b1;
      d.pcount = 5'h00;
    end
    if (q.asm_on && q.burst_on && rclk_rise) begin
      d.asm_word[{q.paddr, 4'h0} +: 16] = parcel;
      if (^{parcel, q.s2_par}) begin
        d.perr = 1'b1;
      end
      d.paddr = q.paddr + 2'h1;
      d.wfp = (q.paddr == dcts_pkg::PARCEL_FINAL);
      d.pcount = q.pcount + 5'h01;
      if (q.pcount == dcts_pkg::BURST_LAST) begin
        d.burst_on = 1'b0;
        d.cont = 1'b1;
      end
    end

    // Drive output unit: restart the drive until the sector is complete
    if (q.cont) begin
      d.bursts = q.bursts + 8'h01;
      if (q.bursts + 8'h01 == dcts_pkg::SECTOR_BURSTS) begin
        d.sector_done = 1'b1;
        d.asm_on = 1'b0;
      end else begin
        d.fdr = 1'b1;
      end
    end

    // Buffer interface unit
    unique case (q.brd)
      dcts_pkg::BUF_IDLE: begin
        if (q.wfp) begin
          d.brd = dcts_pkg::BUF_RD_REQ;
        end
      end
      dcts_pkg::BUF_MODE: begin
        if (d.sync == dcts_pkg::SYNC_MODE) begin
          // Even read or odd write wants a-write mode: strobe b
          d.pa = (q.dir_wr != q.odd);
          d.pb = (q.dir_wr == q.odd);
          d.bcnt = dcts_pkg::PIECES;
          d.brd = q.dir_wr ? dcts_pkg::BUF_WR_CAP : dcts_pkg::BUF_IDLE;
        end
      end
      dcts_pkg::BUF_RD_REQ: begin
        if (d.sync == dcts_pkg::SYNC_MODE) begin
          d.wreq = 1'b1;
          d.brd = dcts_pkg::BUF_RD_ANS;
        end
      end
      dcts_pkg::BUF_RD_ANS: begin
        d.start_wr_a = ~q.odd;
        d.start_wr_b = q.odd;
        d.bshift = {dcts_check(q.asm_word), q.asm_word};
        d.brd = dcts_pkg::BUF_RD_SLOT;
      end
      dcts_pkg::BUF_RD_SLOT: begin
        if (d.sync == dcts_pkg::SYNC_WORD) begin
          d.pa = ~q.odd;
          d.pb = q.odd;
          d.bdata = q.bshift[11:0];
          d.bshift = q.bshift >> dcts_pkg::PIECE_W;
          d.bcnt = dcts_pkg::PIECES - 3'h1;
          d.brd = dcts_pkg::BUF_SEND;
        end
      end
      dcts_pkg::BUF_SEND: begin
        if (q.bcnt != 3'h0) begin
          d.bdata = q.bshift[11:0];
          d.bshift = q.bshift >> dcts_pkg::PIECE_W;
          d.bcnt = q.bcnt - 3'h1;
        end else begin
          d.bdata = 12'h000;
          d.brd = dcts_pkg::BUF_IDLE;
        end
      end
      dcts_pkg::BUF_WR_CAP: begin
        // Board answers a strobe from the next period on, so the strobe cycle is skipped
        if (!(q.pa || q.pb)) begin
          d.wshift = {buf_data_i, q.wshift[71:12]};
          d.bcnt = q.bcnt - 3'h1;
          if (q.bcnt == 3'h1) begin
            d.oword = d.wshift;
            d.ovalid = 1'b1;
            d.brd = dcts_pkg::BUF_WR_HAND;
          end
        end
      end
      dcts_pkg::BUF_WR_HAND: begin
        if (out_word_req_i) begin
          d.brd = dcts_pkg::BUF_WR_SLOT;
        end
      end
      dcts_pkg::BUF_WR_SLOT: begin
        if (d.sync == dcts_pkg::SYNC_WORD) begin
          d.pa = ~q.odd;
          d.pb = q.odd;
          d.bcnt = dcts_pkg::PIECES;
          d.brd = dcts_pkg::BUF_WR_CAP;
        end
      end
    endcase

    // Register port; a hardware set in the same cycle beats the clear
    d.rdata = 16'h0000;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        dcts_pkg::REG_CTRL: d.rdata[dcts_pkg::CTRL_INT_EN] = q.int_en;
        dcts_pkg::REG_PARAM: d.rdata = q.param;
        dcts_pkg::REG_STATUS: begin
          d.rdata[dcts_pkg::ST_DONE] = q.done;
          d.rdata[dcts_pkg::ST_BUSY] = q.busy;
          d.rdata[dcts_pkg::ST_PERR] = q.perr;
          d.rdata[dcts_pkg::ST_WRITE] = q.dir_wr;
          d.rdata[dcts_pkg::ST_ODD] = q.odd;
        end
        default: d.rdata = 16'h0000;
      endcase
    end
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        dcts_pkg::REG_CTRL: d.int_en = reg_wdata_i[dcts_pkg::CTRL_INT_EN];
        dcts_pkg::REG_PARAM: d.param = reg_wdata_i;
        dcts_pkg::REG_STATUS: begin
          if (reg_wdata_i[dcts_pkg::ST_DONE]) begin
            d.done = 1'b0;
          end
          if (reg_wdata_i[dcts_pkg::ST_PERR]) begin
            d.perr = 1'b0;
          end
        end
        default: d.rdata = d.rdata;
      endcase
      if (q.asm_on && q.burst_on && rclk_rise && ^{parcel, q.s2_par}) begin
        d.perr = 1'b1;
      end
    end

    // Write direction finishes on drive-complete alone; its tail is outside this block
    if (q.busy && q.s2_done && (q.sector_done || q.dir_wr)) begin
      d.done = 1'b1;
      d.busy = 1'b0;
      d.asm_on = 1'b0;
      d.brd = dcts_pkg::BUF_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      q <= '0;
      q.fn <= dcts_pkg::FN_IDLE;
      q.brd <= dcts_pkg::BUF_IDLE;
      q.param <= dcts_pkg::PARAM_RESET;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata_o = q.rdata;
  assign irq_o = q.done & q.int_en;
  assign drive_bus_o = q.bus;
  assign drive_code_o = q.code;
  assign drive_fdr_o = q.fdr;
  assign sync_phase_o = q.sync;
  assign buf_data_o = q.bdata;
  assign pointer_a_strobe_o = q.pa;
  assign pointer_b_strobe_o = q.pb;
  assign out_word_o = q.oword;
  assign out_word_valid_o = q.ovalid;
  assign out_clear_o = q.clear;

  default clocking cb_sys @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sync_wrap_a: assert property ((q.sync == 3'h5) |=> (q.sync == 3'h0))
    else $error("sync phase did not wrap after five");
  ptr_slot_a: assert property ((q.pa || q.pb) |-> (q.sync == 3'h2 || q.sync == 3'h3))
    else $error("pointer strobe outside its sync slot");
  code_cont_a: assert property ((q.fdr && q.code != 5'h06) |=> (q.code == 5'h06))
    else $error("request code not forced to six");
  final_req_a: assert property (q.wfp |-> ##[1:7] (q.wreq && q.sync == 3'h2))
    else $error("word request not issued at sync plus two");
  req_answer_a: assert property (q.wreq |=> (q.start_wr_a ^ q.start_wr_b))
    else $error("word request not answered by start write");
  wfp_addr_a: assert property (q.wfp |-> ($past(q.paddr) == 2'h3))
    else $error("final parcel signal at wrong address");
  burst_sixteen_a: assert property (q.cont |-> ($past(q.pcount) == 5'h0F))
    else $error("burst continue not after sixteen parcels");
  cap_six_a: assert property (
    (q.brd == dcts_pkg::BUF_WR_CAP && q.bcnt == 3'h6 && !(q.pa || q.pb))
      |-> (q.brd == dcts_pkg::BUF_WR_CAP)[*6] ##1 q.ovalid)
    else $error("buffer word not captured over six periods");
  done_cause_a: assert property ($rose(q.done) |-> $past(q.s2_done))
    else $error("completion flag without drive complete");
  irq_follow_a: assert property (($rose(q.done) && q.int_en) |-> irq_o)
    else $error("interrupt missing on completion");
  cont_fdr_a: assert property ((q.cont && !q.sector_done && q.bursts != 8'h1F) |=> q.fdr)
    else $error("no request after burst continue");

  read_word_c: cover property (q.brd == dcts_pkg::BUF_SEND && q.bcnt == 3'h0);
  write_word_c: cover property (q.ovalid);
  done_irq_c: cover property ($rose(irq_o));
endmodule : dcts_top

// *** inc/dcts_pkg.sv ***
package dcts_pkg;
  localparam logic [2:0] SYNC_LAST = 3'h5;
  localparam logic [2:0] SYNC_MODE = 3'h2;
  localparam logic [2:0] SYNC_WORD = 3'h3;
  localparam logic [3:0] CMD_TRANSFER = 4'h5;
  localparam logic [1:0] ACC_LAST = 2'h3;
  localparam logic [4:0] CODE_READ = 5'h02;
  localparam logic [4:0] CODE_WRITE = 5'h03;
  localparam logic [4:0] CODE_CONT = 5'h06;
  localparam logic [4:0] BURST_LAST = 5'h0F;
  localparam logic [1:0] PARCEL_FINAL = 2'h3;
  localparam logic [7:0] SECTOR_BURSTS = 8'h20;
  localparam logic [2:0] PIECES = 3'h6;
  localparam int PIECE_W = 12;
  localparam int WORD_W = 64;
  localparam int CB_W = 8;
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_PARAM = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam int CTRL_INT_EN = 0;
  localparam int ST_DONE = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_PERR = 2;
  localparam int ST_WRITE = 3;
  localparam int ST_ODD = 4;
  localparam logic [15:0] PARAM_RESET = 16'h0000;

  typedef enum logic [1:0] {FN_IDLE, FN_CMD, FN_ACC} dcts_fn_t;
  typedef enum logic [3:0] {
    BUF_IDLE, BUF_MODE, BUF_RD_REQ, BUF_RD_ANS, BUF_RD_SLOT, BUF_SEND,
    BUF_WR_CAP, BUF_WR_HAND, BUF_WR_SLOT
  } dcts_buf_t;
endpackage : dcts_pkg

// *** testbench/dcts_drive_model.sv ***
`timescale 1ns/1ps
module dcts_drive_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic fdr_i,
  input wire logic [4:0] code_i,
  input wire logic [9:0] bad_i,
  output logic ready_o,
  output logic rclk_o,
  output logic [15:0] bus_o,
  output logic parity_o,
  output logic done_o
);
  int fdr_n;
  int taken;
  int nb;
  logic [4:0] code_q;
  logic [15:0] p;
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      fdr_n <= 0;
    end else if (fdr_i) begin
      fdr_n <= fdr_n + 1;
      code_q <= code_i;
    end
  end
  // Requests are counted apart so one that lands mid-burst is not lost
  initial begin
    taken = 0;
    nb = 32;
    {ready_o, rclk_o, bus_o, parity_o, done_o} = '0;
    forever begin
      wait (fdr_n > taken);
      @(negedge clk_sys_i);
      taken++;
      if (code_q != 5'h06) begin
        nb = 0;
        done_o = 1'b0;
      end
      if (code_q == 5'h03) begin
        repeat (300) @(posedge clk_sys_i);
        #3 done_o = 1'b1;
      end else if (nb < 32) begin
        // Alternate prompt and slow answers
        repeat ((nb % 2) ? 40 : 3) @(posedge clk_sys_i);
        #17 ready_o = 1'b1;
        for (int j = 0; j < 16; j++) begin
          p = 16'h3C00 + 16'(nb * 16 + j);
          bus_o = p;
          parity_o = ^p ^ (10'(nb * 16 + j) == bad_i);
          #200 rclk_o = 1'b1;
          #200 rclk_o = 1'b0;
        end
        // Clock stands still and the released bus shows the inverse
        ready_o = 1'b0;
        bus_o = ~p;
        parity_o = ~parity_o;
        nb++;
        if (nb == 32) begin
          repeat (20) @(posedge clk_sys_i);
          #3 done_o = 1'b1;
        end
      end
      if (done_o) begin
        repeat (100) @(posedge clk_sys_i);
        done_o = 1'b0;
      end
    end
  end
endmodule : dcts_drive_model

// *** testbench/test_dcts_top.sv ***
`timescale 1ns/1ps
module test_dcts_top;
  typedef struct packed {
    logic wr;
    logic [1:0] addr;
    logic [15:0] data;
  } dcts_row_t;
  logic clk_sys_i, rst_i, function_strobe_i, reg_wr_i, reg_rd_i, irq_o, drive_ready_i;
  logic drive_read_clk_i, drive_parity_i, drive_done_i, drive_fdr_o, pointer_a_strobe_o;
  logic pointer_b_strobe_o, out_word_valid_o, out_clear_o, out_word_req_i, wr_dir, mode_b, odd;
  logic ph_ok;
  logic [3:0] function_nibble_i;
  logic [1:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, drive_bus_i, drive_bus_o, st;
  logic [4:0] drive_code_o;
  logic [2:0] sync_phase_o, ph_prev;
  logic [11:0] buf_data_i, buf_data_o;
  logic [71:0] out_word_o, acc;
  logic [9:0] bad;
  int error_cnt, n_checks, fdr_n, clr_n, mode_n, rw, wi, bw, bp, pc, sw, f0, c0, m0;
  dcts_row_t rows[10] = '{
    '{1'b0, 2'h0, 16'h0000}, '{1'b0, 2'h1, 16'h0000}, '{1'b0, 2'h2, 16'h0000},
    '{1'b1, 2'h1, 16'hBEEF}, '{1'b0, 2'h1, 16'hBEEF}, '{1'b1, 2'h0, 16'h0001},
    '{1'b0, 2'h0, 16'h0001}, '{1'b1, 2'h3, 16'hFFFF}, '{1'b0, 2'h3, 16'h0000},
    '{1'b1, 2'h0, 16'h0000}};
  dcts_top dut (.clk_sys_i, .rst_i, .function_strobe_i, .function_nibble_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o, .drive_ready_i, .drive_read_clk_i,
    .drive_bus_i, .drive_parity_i, .drive_done_i, .drive_bus_o, .drive_code_o, .drive_fdr_o,
    .sync_phase_o, .buf_data_i, .buf_data_o, .pointer_a_strobe_o, .pointer_b_strobe_o,
    .out_word_o, .out_word_valid_o, .out_clear_o, .out_word_req_i);
  dcts_drive_model drive (.clk_sys_i, .rst_i, .fdr_i(drive_fdr_o), .code_i(drive_code_o),
    .bad_i(bad), .ready_o(drive_ready_i), .rclk_o(drive_read_clk_i), .bus_o(drive_bus_i),
    .parity_o(drive_parity_i), .done_o(drive_done_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input string nm, input logic [71:0] got, input logic [71:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  function automatic logic [71:0] rword(input int w);
    logic [63:0] d;
    logic [7:0] cb;
    for (int i = 0; i < 4; i++)
      d[16*i+:16] = 16'h3C00 + 16'(4 * w + i);
    for (int k = 0; k < 8; k++)
      cb[k] = ^(d & (64'h0101010101010101 << k));
    return {cb, d};
  endfunction : rword
  function automatic logic [71:0] wword(input int w);
    logic [71:0] r;
    for (int k = 0; k < 6; k++)
      r[12*k+:12] = {4'(w), 4'hC, 4'(k)};
    return r;
  endfunction : wword
  task automatic reg_wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : reg_rd
  task automatic xfer(input logic [4:0] code);
    logic [15:0] a;
    a = {11'h000, code};
    @(posedge clk_sys_i);
    function_strobe_i <= 1'b1;
    function_nibble_i <= {3'h0, odd};
    @(posedge clk_sys_i);
    function_strobe_i <= 1'b0;
    function_nibble_i <= dcts_pkg::CMD_TRANSFER;
    for (int i = 3; i >= 0; i--) begin
      @(posedge clk_sys_i);
      function_nibble_i <= a[4*i+:4];
    end
    @(posedge clk_sys_i);
    function_nibble_i <= 4'h0;
    for (int k = 0; k < 3; k++) begin
      #1;
      if (drive_fdr_o === 1'b1) break;
      @(posedge clk_sys_i);
    end
    chk("fdr", drive_fdr_o, 1'b1);
    chk("bus_out", drive_bus_o, 16'hA5C0);
    chk("code", drive_code_o, code);
    @(posedge clk_sys_i);
    #1 chk("code_cont", drive_code_o, dcts_pkg::CODE_CONT);
  endtask : xfer
  always @(posedge clk_sys_i) begin
    ph_prev <= sync_phase_o;
    ph_ok <= !rst_i;
    if (ph_ok && !rst_i)
      chk("ph", sync_phase_o, (ph_prev + 3'h1) % 3'h6);
    if (drive_fdr_o) fdr_n <= fdr_n + 1;
    if (out_clear_o) clr_n <= clr_n + 1;
    // A word is compared one edge after its sixth piece lands
    if (pc == 6) begin
      if (!wr_dir) chk("rd_word", acc, rword(rw));
      rw <= rw + 1;
      pc <= 0;
    end
    if (pointer_a_strobe_o || pointer_b_strobe_o) begin
      chk("ptr_pair", pointer_a_strobe_o & pointer_b_strobe_o, 1'b0);
      if (sync_phase_o == dcts_pkg::SYNC_MODE) begin
        mode_n <= mode_n + 1;
        chk("mode_ptr", pointer_b_strobe_o, mode_b);
        sw = 0;
      end else begin
        chk("word_ph", sync_phase_o, dcts_pkg::SYNC_WORD);
        chk("word_ptr", pointer_b_strobe_o, odd);
        sw = bw + 1;
        pc <= 1;
        acc[11:0] <= buf_data_o;
      end
      bw <= sw;
      bp <= 1;
      buf_data_i <= {4'(sw), 8'hC0};
    end else begin
      if (pc > 0 && pc < 6) begin
        acc[12*pc+:12] <= buf_data_o;
        pc <= pc + 1;
      end
      // Idle buffer data toggles so a mistimed capture cannot match by chance
      buf_data_i <= (bp < 6) ? {4'(bw), 4'hC, 4'(bp)} : ~buf_data_i;
      bp <= bp + 1;
    end
    if (out_word_valid_o) begin
      chk("wr_word", out_word_o, wword(wi));
      wi <= wi + 1;
    end
  end
  initial begin
    rst_i = 1'b1;
    {function_strobe_i, reg_wr_i, reg_rd_i, out_word_req_i, wr_dir, mode_b, odd} = '0;
    function_nibble_i = 4'h0;
    reg_addr_i = 2'h0;
    reg_wdata_i = 16'h0000;
    buf_data_i = 12'h000;
    bad = 10'h3FF;
    repeat (8) @(posedge clk_sys_i);
    chk("rst_out", {irq_o, reg_rdata_o, drive_bus_o, drive_code_o, drive_fdr_o, sync_phase_o,
      buf_data_o, pointer_a_strobe_o, pointer_b_strobe_o, out_word_valid_o, out_clear_o}, 0);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        reg_wr(rows[i].addr, rows[i].data);
      end else begin
        reg_rd(rows[i].addr, st);
        chk("reg", st, rows[i].data);
      end
    end
    for (int t = 0; t < 4; t++) begin
      reg_wr(dcts_pkg::REG_PARAM, 16'hA5C0);
      reg_wr(dcts_pkg::REG_CTRL, 16'(t == 0));
      #1;
      odd = t[0];
      wr_dir = t[1];
      mode_b = wr_dir ? odd : !odd;
      bad = (t == 1) ? 10'h005 : 10'h3FF;
      rw = 0;
      wi = 0;
      f0 = fdr_n;
      c0 = clr_n;
      m0 = mode_n;
      xfer(wr_dir ? dcts_pkg::CODE_WRITE : dcts_pkg::CODE_READ);
      reg_rd(dcts_pkg::REG_STATUS, st);
      chk("status", st[4:0], {odd, wr_dir, 3'b010});
      for (int w = 0; wr_dir && w < 3; w++) begin
        for (int k = 0; k < 60 && out_word_valid_o !== 1'b1; k++)
          @(posedge clk_sys_i);
        out_word_req_i <= 1'b1;
        @(posedge clk_sys_i);
        out_word_req_i <= 1'b0;
      end
      for (int k = 0; k < 4000; k++) begin
        reg_rd(dcts_pkg::REG_STATUS, st);
        if (st[dcts_pkg::ST_DONE] === 1'b1) break;
      end
      chk("done", st[dcts_pkg::ST_DONE], 1'b1);
      chk("perr", st[dcts_pkg::ST_PERR], t == 1);
      chk("irq", irq_o, t == 0);
      chk("bursts", fdr_n - f0, wr_dir ? 1 : 32);
      chk("mode_once", mode_n - m0, 1);
      chk("clear", clr_n - c0, wr_dir);
      chk("words", wr_dir ? wi : rw, wr_dir ? 4 : 128);
      repeat (120) @(posedge clk_sys_i);
      reg_wr(dcts_pkg::REG_CTRL, 16'h0000);
      #1 chk("irq_off", irq_o, 1'b0);
      reg_wr(dcts_pkg::REG_STATUS, 16'h0005);
      reg_rd(dcts_pkg::REG_STATUS, st);
      chk("w1c", st[4:0] & 5'h05, 5'h00);
    end
    conclude();
  end
  initial begin
    #(40000 * 50);
    error_cnt++;
    conclude();
  end
endmodule : test_dcts_top
